// file: hdl/mcr_pkg.sv
// Shared constants and carriers for the command register block
package mcr_pkg;

  // Register map
  localparam logic [7:0]  CMD_REG_OFFSET  = 8'h00;        // Byte offset of command_register
  localparam logic [31:0] CMD_REG_RESET   = 32'h00000000; // Hard and soft reset value

  // Field positions inside command_register
  localparam int BIT_TX_ENABLE   = 0;  // transmit_enable
  localparam int BIT_TX_DISABLE  = 1;  // Transmit disable, write-only
  localparam int BIT_RX_ENABLE   = 2;  // receive_enable
  localparam int BIT_RX_DISABLE  = 3;  // Receive disable, write-only
  localparam int BIT_TX_PATH_RST = 4;  // transmit_path_reset
  localparam int BIT_RX_PATH_RST = 5;  // receive_path_reset
  localparam int BIT_SW_INT      = 7;  // software_interrupt_request
  localparam int BIT_SOFT_RST    = 8;  // Full software reset

  // Soft reset duration
  localparam int CLK_PERIOD_NS  = 8;     // Core clock period
  localparam int SOFT_RST_NS    = 1000;  // Least time the soft reset is held
  localparam int SOFT_RST_CYC_I = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SOFT_RST_CYC = SOFT_RST_CYC_I[7:0]; // 125 cycles

  // Register access request from the host side
  typedef struct packed {
    logic        wr;     // Write strobe, one cycle
    logic        rd;     // Read strobe, one cycle
    logic [7:0]  addr;   // Byte offset
    logic [31:0] wdata;  // Write data
  } mcr_req_t;

  // Command pulses to one data path
  typedef struct packed {
    logic reset;  // Abort and discard, force idle
    logic start;  // Activate state machine
    logic stop;   // Request disable
  } mcr_path_cmd_t;

  // Soft reset sequencer states
  typedef enum logic [0:0] {
    SEQ_IDLE,
    SEQ_HOLD
  } mcr_seq_e_t;

  // Sequencer state
  typedef struct packed {
    mcr_seq_e_t state;  // Current state
    logic [7:0] count;  // Cycles left in hold
    logic       busy;   // Reset in progress
    logic       done;   // Completion pulse
  } mcr_seq_t;

  // Command register state
  typedef struct packed {
    logic          tx_en;         // Transmit machine active
    logic          rx_en;         // Receive machine active
    logic          tx_stop_pend;  // Transmit disable waiting for idle
    logic          rx_stop_pend;  // Receive disable waiting for idle
    mcr_path_cmd_t tx_cmd;        // Transmit command pulses
    mcr_path_cmd_t rx_cmd;        // Receive command pulses
    logic          software_interrupt_request;           // Software interrupt pulse
    logic          rvalid;        // Read data valid pulse
    logic [31:0]   rdata;         // Read data
  } mcr_state_t;

endpackage

// file: hdl/mcr_reset_seq.sv
`timescale 1ns/1ns
// Holds the soft reset for a fixed number of cycles, then releases it
module mcr_reset_seq (
  input  wire logic i_ref_clk,  // Core clock
  input  wire logic i_reset,    // Hard reset, sync, active high
  input  wire logic i_start,    // Start request pulse
  output logic      o_busy,     // Soft reset level
  output logic      o_done      // Completion pulse
);

  mcr_pkg::mcr_seq_t st_r;   // Registered state
  mcr_pkg::mcr_seq_t st_nxt; // Next state

  // Next state logic
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    case (st_r.state)
      mcr_pkg::SEQ_IDLE: begin
        // Start a new hold period
        if (i_start) begin
          st_nxt.state = mcr_pkg::SEQ_HOLD;
          st_nxt.count = mcr_pkg::SOFT_RST_CYC - 8'h01;
          st_nxt.busy  = 1'b1;
        end
      end
      mcr_pkg::SEQ_HOLD: begin
        // Count down, release at zero
        if (st_r.count == 8'h00) begin
          st_nxt.state = mcr_pkg::SEQ_IDLE;
          st_nxt.busy  = 1'b0;
          st_nxt.done  = 1'b1;
        end else begin
          st_nxt.count = st_r.count - 8'h01;
        end
      end
      default: begin
        st_nxt = '0;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_busy = st_r.busy;
  assign o_done = st_r.done;

endmodule

// file: hdl/mcr_command_register.sv
`timescale 1ns/1ns
//
// Contract
// - Write 1 runs command; all bits reset zero
// - Bit 8 full reset, includes both path resets
// - Reset bit reads 1, self clears
// - Bit 7 raises interrupt, gated by mask
// - Bit 5 aborts receive, receiver goes idle
// - Bit 4 aborts transmit, transmitter goes idle
// - Bit 3 disables receiver, reads zero
// - Bit 2 enables receiver, reads active state
// - Bit 1 disables transmitter, reads zero
// - Bit 0 enables transmitter, reads active state
// - Host access; reserved writes ignored
module mcr_command_register (
  input  wire logic                   i_ref_clk,          // Core clock, 125 MHz
  input  wire logic                   i_reset,            // Hard reset, sync, active high
  input  wire mcr_pkg::mcr_req_t      i_reg_req,          // Host register request
  input  wire logic                   i_tx_idle,          // Transmit machine is idle
  input  wire logic                   i_rx_idle,          // Receive machine is idle
  input  wire logic                   i_swi_unmasked,     // Mask lets soft interrupt through
  output logic [31:0]                 o_reg_rdata,        // Read data
  output logic                        o_reg_rvalid,       // Read data valid pulse
  output mcr_pkg::mcr_path_cmd_t      o_tx_cmd,           // Transmit path command pulses
  output mcr_pkg::mcr_path_cmd_t      o_rx_cmd,           // Receive path command pulses
  output logic                        o_transmit_enable,  // Transmit machine active
  output logic                        o_receive_enable,   // Receive machine active
  output logic                        o_soft_reset,       // Soft reset level to the chip
  output logic                        o_sw_interrupt      // Software interrupt pulse
);

  // True when an offset selects command_register
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr == mcr_pkg::CMD_REG_OFFSET);
  endfunction

  mcr_pkg::mcr_state_t st_r;    // Registered state
  mcr_pkg::mcr_state_t st_nxt;  // Next state
  logic                seq_busy; // Soft reset in progress
  logic                seq_start; // Soft reset request
  logic                seq_done; // Soft reset completion pulse
  logic [31:0]         wr_bits;  // Write data when this register is hit
  logic                rd_hit;   // Read of this register
  logic [31:0]         rd_value; // Live read image

  // Write decode; other offsets see no bits at all
  always_comb begin
    wr_bits = '0;
    if (i_reg_req.wr && addr_hit(i_reg_req.addr)) begin
      wr_bits = i_reg_req.wdata;
    end
  end

  assign rd_hit    = i_reg_req.rd && addr_hit(i_reg_req.addr);
  assign seq_start = wr_bits[mcr_pkg::BIT_SOFT_RST] && !seq_busy;

  // Soft reset timer
  mcr_reset_seq mcr_reset_seq_inst (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_start   (seq_start),
    .o_busy    (seq_busy),
    .o_done    (seq_done)
  );

  // Read image: write-only and command bits read zero, except bit 8 reads busy and bits 2 and 0 read the enables
  always_comb begin
    rd_value                         = mcr_pkg::CMD_REG_RESET;
    rd_value[mcr_pkg::BIT_SOFT_RST]  = seq_busy;
    rd_value[mcr_pkg::BIT_RX_ENABLE] = st_r.rx_en;
    rd_value[mcr_pkg::BIT_TX_ENABLE] = st_r.tx_en;
  end

  // Next state of the command logic
  always_comb begin
    st_nxt        = st_r;
    st_nxt.tx_cmd = '0;
    st_nxt.rx_cmd = '0;
    st_nxt.software_interrupt_request    = 1'b0;
    st_nxt.rvalid = 1'b0;

    // Read returns the live image
    if (rd_hit) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_value;
    end

    // Disables complete once the machine reports idle
    if (st_r.tx_stop_pend && i_tx_idle) begin
      st_nxt.tx_en        = 1'b0;
      st_nxt.tx_stop_pend = 1'b0;
    end
    if (st_r.rx_stop_pend && i_rx_idle) begin
      st_nxt.rx_en        = 1'b0;
      st_nxt.rx_stop_pend = 1'b0;
    end

    if (seq_busy || seq_start) begin
      // Soft reset: enables and pending disables back to zero, both paths reset
      st_nxt.tx_en        = 1'b0;
      st_nxt.rx_en        = 1'b0;
      st_nxt.tx_stop_pend = 1'b0;
      st_nxt.rx_stop_pend = 1'b0;
      st_nxt.tx_cmd.reset = seq_start;
      st_nxt.rx_cmd.reset = seq_start;
    end else begin
      // Software interrupt, gated by the mask
      if (wr_bits[mcr_pkg::BIT_SW_INT]) begin
        st_nxt.software_interrupt_request = i_swi_unmasked;
      end

      // Transmit path
      if (wr_bits[mcr_pkg::BIT_TX_PATH_RST]) begin
        st_nxt.tx_cmd.reset = 1'b1;
        st_nxt.tx_en        = 1'b0;
        st_nxt.tx_stop_pend = 1'b0;
      end else if (wr_bits[mcr_pkg::BIT_TX_DISABLE]) begin
        st_nxt.tx_cmd.stop  = 1'b1;
        st_nxt.tx_stop_pend = 1'b1;
      end else if (wr_bits[mcr_pkg::BIT_TX_ENABLE]) begin
        st_nxt.tx_cmd.start = 1'b1;
        st_nxt.tx_en        = 1'b1;
      end

      // Receive path
      if (wr_bits[mcr_pkg::BIT_RX_PATH_RST]) begin
        st_nxt.rx_cmd.reset = 1'b1;
        st_nxt.rx_en        = 1'b0;
        st_nxt.rx_stop_pend = 1'b0;
      end else if (wr_bits[mcr_pkg::BIT_RX_DISABLE]) begin
        st_nxt.rx_cmd.stop  = 1'b1;
        st_nxt.rx_stop_pend = 1'b1;
      end else if (wr_bits[mcr_pkg::BIT_RX_ENABLE]) begin
        st_nxt.rx_cmd.start = 1'b1;
        st_nxt.rx_en        = 1'b1;
      end
    end
  end

  // State register, cleared by hard reset
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign o_reg_rdata       = st_r.rdata;
  assign o_reg_rvalid      = st_r.rvalid;
  assign o_tx_cmd          = st_r.tx_cmd;
  assign o_rx_cmd          = st_r.rx_cmd;
  assign o_transmit_enable = st_r.tx_en;
  assign o_receive_enable  = st_r.rx_en;
  assign o_soft_reset      = seq_busy;
  assign o_sw_interrupt    = st_r.software_interrupt_request;

  // Soft reset reads back as one while active
  rst_readback_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    rd_hit && seq_busy |=> o_reg_rdata[mcr_pkg::BIT_SOFT_RST])
    else $error("Reset bit did not read as one during soft reset");

  // Soft reset lasts exactly its hold time
  rst_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    $rose(seq_busy) |-> ##124 seq_busy ##1 !seq_busy)
    else $error("Soft reset length is wrong");

  // Soft reset resets both paths and clears enables
  rst_paths_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    seq_start |=> o_tx_cmd.reset && o_rx_cmd.reset && o_soft_reset
                  && !o_transmit_enable && !o_receive_enable)
    else $error("Soft reset did not reset both paths");

  // Enables stay clear throughout soft reset
  rst_zero_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    seq_busy |=> !o_transmit_enable && !o_receive_enable)
    else $error("Enable set during soft reset");

  // Software interrupt follows the mask
  swi_mask_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    wr_bits[mcr_pkg::BIT_SW_INT] && !seq_busy && !seq_start
      |=> o_sw_interrupt == $past(i_swi_unmasked))
    else $error("Software interrupt not gated by mask");

  // Receive path reset forces idle
  rx_reset_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    wr_bits[mcr_pkg::BIT_RX_PATH_RST] && !seq_busy
      |=> o_rx_cmd.reset && !o_receive_enable)
    else $error("Receive path reset did not idle receiver");

  // Transmit path reset forces idle
  tx_reset_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    wr_bits[mcr_pkg::BIT_TX_PATH_RST] && !seq_busy
      |=> o_tx_cmd.reset && !o_transmit_enable)
    else $error("Transmit path reset did not idle transmitter");

  // Disable bits never read back
  wonly_read_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_reg_rvalid |-> !o_reg_rdata[mcr_pkg::BIT_RX_DISABLE]
                     && !o_reg_rdata[mcr_pkg::BIT_TX_DISABLE])
    else $error("Write-only disable bit read as one");

  // Receive disable completes on idle
  rx_disable_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    st_r.rx_stop_pend && i_rx_idle && !wr_bits[mcr_pkg::BIT_RX_ENABLE]
      |=> !o_receive_enable)
    else $error("Receiver disable did not clear enable");

  // Receive enable reads the active state
  rx_readback_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    rd_hit |=> o_reg_rdata[mcr_pkg::BIT_RX_ENABLE] == $past(o_receive_enable))
    else $error("Receive enable readback mismatch");

  // Transmit enable starts the machine
  tx_start_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    wr_bits[mcr_pkg::BIT_TX_ENABLE] && !wr_bits[mcr_pkg::BIT_TX_DISABLE]
      && !wr_bits[mcr_pkg::BIT_TX_PATH_RST] && !seq_busy && !seq_start
      |=> o_transmit_enable && o_tx_cmd.start)
    else $error("Transmit enable did not start transmitter");

  // Transmit disable wins over enable in one write
  both_bits_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    wr_bits[mcr_pkg::BIT_TX_ENABLE] && wr_bits[mcr_pkg::BIT_TX_DISABLE]
      |=> !o_tx_cmd.start)
    else $error("Enable honoured alongside disable");

  // Writes elsewhere leave the transmit enable alone
  reserved_wr_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    i_reg_req.wr && !addr_hit(i_reg_req.addr) && !seq_busy && !st_r.tx_stop_pend
      && !rd_hit
      |=> o_transmit_enable == $past(o_transmit_enable))
    else $error("Write to other offset changed transmit enable");

  // Completion pulse comes as the reset level drops
  rst_done_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    seq_done |-> !o_soft_reset && $past(o_soft_reset))
    else $error("Soft reset completion out of step");

  // Reset bit reads zero once the reset is over
  rst_clear_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    rd_hit && !seq_busy |=> !o_reg_rdata[mcr_pkg::BIT_SOFT_RST])
    else $error("Reset bit read as one when idle");

  // Transmit disable write pulses stop only
  tx_stop_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    wr_bits[mcr_pkg::BIT_TX_DISABLE] && !wr_bits[mcr_pkg::BIT_TX_PATH_RST]
      && !seq_busy && !seq_start
      |=> o_tx_cmd.stop && !o_tx_cmd.start)
    else $error("Transmit disable did not pulse stop");

  // Transmit disable completes on idle
  tx_disable_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    st_r.tx_stop_pend && i_tx_idle && !wr_bits[mcr_pkg::BIT_TX_ENABLE]
      |=> !o_transmit_enable)
    else $error("Transmitter disable did not clear enable");

  // Transmit enable reads the active state
  tx_readback_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    rd_hit |=> o_reg_rdata[mcr_pkg::BIT_TX_ENABLE] == $past(o_transmit_enable))
    else $error("Transmit enable readback mismatch");

  // Receive enable starts the machine
  rx_start_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    wr_bits[mcr_pkg::BIT_RX_ENABLE] && !wr_bits[mcr_pkg::BIT_RX_DISABLE]
      && !wr_bits[mcr_pkg::BIT_RX_PATH_RST] && !seq_busy && !seq_start
      |=> o_receive_enable && o_rx_cmd.start)
    else $error("Receive enable did not start receiver");

  // Receive disable wins over enable in one write
  rx_both_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    wr_bits[mcr_pkg::BIT_RX_ENABLE] && wr_bits[mcr_pkg::BIT_RX_DISABLE]
      && !wr_bits[mcr_pkg::BIT_RX_PATH_RST] && !seq_busy && !seq_start
      |=> o_rx_cmd.stop && !o_rx_cmd.start)
    else $error("Receive enable honoured alongside disable");

  // Reads elsewhere get no answer
  rd_unmapped_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    i_reg_req.rd && !addr_hit(i_reg_req.addr) |=> !o_reg_rvalid)
    else $error("Read of other offset was answered");

  // Interrupt pulse only follows a write of its bit
  swi_only_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    !wr_bits[mcr_pkg::BIT_SW_INT] |=> !o_sw_interrupt)
    else $error("Software interrupt without a write");

endmodule

// file: tb/mcr_command_register_tb.sv
`timescale 1ns/1ns
module mcr_command_register_tb;
  logic                   i_ref_clk;   // Core clock
  logic                   i_reset;     // Hard reset
  mcr_pkg::mcr_req_t      req;         // Host request
  logic                   tx_idle;     // Transmit idle level
  logic                   rx_idle;     // Receive idle level
  logic                   swi_unm;     // Mask lets soft interrupt through
  logic [31:0]            rdata;       // Read data
  logic                   rvalid;      // Read valid pulse
  mcr_pkg::mcr_path_cmd_t tx_cmd;      // Transmit pulses
  mcr_pkg::mcr_path_cmd_t rx_cmd;      // Receive pulses
  logic                   tx_en;       // Transmit active
  logic                   rx_en;       // Receive active
  logic                   soft_rst;    // Soft reset level
  logic                   sw_int;      // Soft interrupt pulse
  int                     n_errors;    // Mismatch count
  int                     n_tests;     // Comparison count
  int                     cycles;      // Hang guard

  mcr_command_register mcr_command_register_inst (
    .i_ref_clk         (i_ref_clk),
    .i_reset           (i_reset),
    .i_reg_req         (req),
    .i_tx_idle         (tx_idle),
    .i_rx_idle         (rx_idle),
    .i_swi_unmasked    (swi_unm),
    .o_reg_rdata       (rdata),
    .o_reg_rvalid      (rvalid),
    .o_tx_cmd          (tx_cmd),
    .o_rx_cmd          (rx_cmd),
    .o_transmit_enable (tx_en),
    .o_receive_enable  (rx_en),
    .o_soft_reset      (soft_rst),
    .o_sw_interrupt    (sw_int)
  );

  // Clock, 8 ns period
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  // Cut a hang short
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end

  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Idle cycle, then one write strobe; returns in the cycle after it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_ref_clk);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(negedge i_ref_clk);
    req.wr    = 1'b0;
  endtask

  // Idle cycle, then one read strobe at offset 0, checks the answer
  task automatic rd_chk(input logic [31:0] exp);
    @(negedge i_ref_clk);
    req.rd   = 1'b1;
    req.addr = 8'h00;
    @(negedge i_ref_clk);
    req.rd   = 1'b0;
    chk("rvalid", 1'b1, rvalid);
    chk("rdata", exp, rdata);
  endtask

  // Reset value of every bit
  task automatic t_reset_value();
    chk("tx_en", 1'b0, tx_en);
    chk("soft", 1'b0, soft_rst);
    chk("outs", 32'h0, {rx_en, sw_int, rvalid, tx_cmd, rx_cmd});
    rd_chk(32'h00000000);
    $display("test reset_value done");
  endtask

  // Enables pulse start and read back as active
  task automatic t_enable();
    wr(8'h00, 32'h00000001);
    chk("tx start", 1'b1, tx_cmd.start);
    chk("tx_en", 1'b1, tx_en);
    wr(8'h00, 32'h00000004);
    chk("rx start", 1'b1, rx_cmd.start);
    chk("tx start low", 1'b0, tx_cmd.start);
    rd_chk(32'h00000005);
    $display("test enable done");
  endtask

  // Disables wait for idle; disable bits read zero
  task automatic t_disable();
    wr(8'h00, 32'h00000002);
    chk("tx stop", 1'b1, tx_cmd.stop);
    repeat (3) @(negedge i_ref_clk);
    chk("tx_en held", 1'b1, tx_en);
    rd_chk(32'h00000005);
    tx_idle = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    chk("tx_en off", 1'b0, tx_en);
    tx_idle = 1'b0;
    wr(8'h00, 32'h00000008);
    chk("rx stop", 1'b1, rx_cmd.stop);
    chk("rx_en held", 1'b1, rx_en);
    rx_idle = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    chk("rx_en off", 1'b0, rx_en);
    rx_idle = 1'b0;
    rd_chk(32'h00000000);
    $display("test disable done");
  endtask

  // Path resets drop the enables at once
  task automatic t_path_reset();
    wr(8'h00, 32'h00000005);
    wr(8'h00, 32'h00000030);
    chk("tx reset", 1'b1, tx_cmd.reset);
    chk("rx reset", 1'b1, rx_cmd.reset);
    chk("tx_en", 1'b0, tx_en);
    chk("rx_en", 1'b0, rx_en);
    @(negedge i_ref_clk);
    chk("tx reset low", 1'b0, tx_cmd.reset);
    rd_chk(32'h00000000);
    $display("test path_reset done");
  endtask

  // Enable with disable in one write: disable only
  task automatic t_both();
    wr(8'h00, 32'h0000000f);
    chk("tx start", 1'b0, tx_cmd.start);
    chk("tx stop", 1'b1, tx_cmd.stop);
    chk("rx start", 1'b0, rx_cmd.start);
    chk("rx stop", 1'b1, rx_cmd.stop);
    chk("en", 2'b00, {tx_en, rx_en});
    $display("test both done");
  endtask

  // Soft interrupt honours the mask
  task automatic t_swi();
    swi_unm = 1'b1;
    wr(8'h00, 32'h00000080);
    chk("swi", 1'b1, sw_int);
    @(negedge i_ref_clk);
    chk("swi low", 1'b0, sw_int);
    swi_unm = 1'b0;
    wr(8'h00, 32'h00000080);
    chk("swi masked", 1'b0, sw_int);
    rd_chk(32'h00000000);
    $display("test swi done");
  endtask

  // Other offsets have no effect and no answer
  task automatic t_unmapped();
    wr(8'h04, 32'h00000005);
    chk("start", 1'b0, tx_cmd.start);
    chk("en", 2'b00, {tx_en, rx_en});
    req.rd   = 1'b1;
    req.addr = 8'h04;
    @(negedge i_ref_clk);
    req.rd   = 1'b0;
    chk("rvalid", 1'b0, rvalid);
    $display("test unmapped done");
  endtask

  // Soft reset: pulses, busy read, timed release
  task automatic t_soft_reset();
    int n;
    wr(8'h00, 32'h00000001);
    wr(8'h00, 32'h00000100);
    chk("soft", 1'b1, soft_rst);
    chk("resets", 2'b11, {tx_cmd.reset, rx_cmd.reset});
    chk("tx_en", 1'b0, tx_en);
    rd_chk(32'h00000100);
    wr(8'h00, 32'h00000001);
    chk("start", 1'b0, tx_cmd.start);
    n = 4;
    while (soft_rst === 1'b1 && n < 300) begin
      n = n + 1;
      @(negedge i_ref_clk);
    end
    chk("hold", 32'(mcr_pkg::SOFT_RST_CYC), 32'(n));
    rd_chk(32'h00000000);
    $display("test soft_reset done");
  endtask

  // Hard reset in mid-run clears every bit
  task automatic t_hard_reset();
    wr(8'h00, 32'h00000005);
    chk("en on", 2'b11, {tx_en, rx_en});
    i_reset = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_reset = 1'b0;
    chk("en", 2'b00, {tx_en, rx_en});
    chk("soft", 1'b0, soft_rst);
    rd_chk(32'h00000000);
    $display("test hard_reset done");
  endtask

  // Counts and verdict
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    n_errors = 0;
    n_tests  = 0;
    cycles   = 0;
    i_reset  = 1'b1;
    req      = '0;
    tx_idle  = 1'b0;
    rx_idle  = 1'b0;
    swi_unm  = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    i_reset  = 1'b0;
    t_reset_value();
    t_enable();
    t_disable();
    t_path_reset();
    t_both();
    t_swi();
    t_unmapped();
    t_soft_reset();
    t_hard_reset();
    close_out();
  end
endmodule
